/* File: src/fifo_flags_pkg.sv */
// Purpose: shared constants and types for the flagged synchronous fifo
// Assumes: one system clock; fifo clocks arrive as sampled pins
// Notes:   register offsets are byte addresses on a 32-bit bus
package fifo_flags_pkg;

    // data path and depth
    localparam int DATA_W         = 9;
    localparam int ADDR_W_DEFAULT = 8;
    localparam int ADDR_W_MIN     = 8;
    localparam int ADDR_W_MAX     = 13;
    localparam int OFF_LO_W       = 8;
    localparam int OFF_EXT_W      = 17;
    localparam int OFFSET_DEFAULT = 7;

    // register bus
    localparam int          AXI_ADDR_W = 12;
    localparam int          AXI_DATA_W = 32;
    localparam logic [11:0] REG_STATUS = 12'h000;
    localparam logic [11:0] REG_OFFSET = 12'h004;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // status word fields
    localparam int ST_FULL_N      = 0;
    localparam int ST_ALMOST_FULL = 1;
    localparam int ST_ALMOST_EMPT = 2;
    localparam int ST_EMPTY_N     = 3;
    localparam int ST_DUAL_MODE   = 4;
    localparam int ST_COUNT_LSB   = 16;

    // offset word fields
    localparam int OF_EMPTY_LSB = 0;
    localparam int OF_FULL_LSB  = 16;

    // offset register walk, shared by load writes and load reads
    typedef enum logic [3:0] {
        SEL_EMPTY_LO = 4'b0001,
        SEL_EMPTY_HI = 4'b0010,
        SEL_FULL_LO  = 4'b0100,
        SEL_FULL_HI  = 4'b1000
    } offset_sel_t;

endpackage : fifo_flags_pkg

/* File: src/fifo_flags.sv */
// Purpose: one 9-bit fifo with full, empty, almost-full, almost-empty flags
// Assumes: fifo write and read clocks are pins sampled on CLK_IN
// Notes:   offsets reachable both by the load pin sequence and over AXI4-Lite
//
// What this block does
// (R1) Full flag low at full depth; further writes refused.
// (R2) Full and almost-full change only on write-clock rising edges.
// (R3) Empty flag low when pointers are equal; further reads refused.
// (R4) Empty and almost-empty change only on read-clock rising edges.
// (R5) Almost-full low once count reaches depth minus full offset.
// (R6) Full offset defaults to seven.
// (R7) Almost-empty low at n words or fewer, high from n+1.
// (R8) Empty offset defaults to seven.
// (R9) Flag levels follow occupancy: empty, partial, almost-full, full bands.
// (R10) Nine-bit read data matches nine-bit write data.
// (R11) Pin level at reset picks second write enable or offset load.
// (R12) After reset read data is zero when enabled, released otherwise.
// (R13) Reset works while both fifo clocks keep toggling.
// (R14) Full flags may lag one write edge after a close read edge.
// (R15) Empty flags may lag one read edge after a close write edge.
// (R16) Empty flag clears within one or two read-clock periods.
// (R17) Dual-enable mode: either enable inactive blocks the write.
// (R18) Write on almost-full edge leaves depth minus (m-1) words.
// (R19) Read on almost-empty edge leaves n-1 words.
// (R20) Reset clears both pointers and restores default offsets.
// (R21) Reader drives both read enables low to advance output register.
// (R22) Load writes walk empty-lo, empty-hi, full-lo, full-hi, then wrap.
// (R23) Output enable high releases bus; low drives output register.
// (R24) Pointers cross between sides as gray code through two flops.
// (R25) Depth is a power of two; offsets sized to match.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module fifo_flags #(
    parameter int ADDR_W = fifo_flags_pkg::ADDR_W_DEFAULT
) (
    // system
    input  wire logic                                   CLK_IN,
    input  wire logic                                   RESETN_IN,
    // write port
    input  wire logic                                   WRITE_CLOCK_IN,
    input  wire logic [fifo_flags_pkg::DATA_W-1:0]      WRITE_DATA_IN,
    input  wire logic                                   WRITE_ENABLE_ONE_N_IN,
    input  wire logic                                   WRITE_ENABLE_TWO_OR_LOAD_IN,
    // read port
    input  wire logic                                   READ_CLOCK_IN,
    input  wire logic                                   READ_ENABLE_ONE_N_IN,
    input  wire logic                                   READ_ENABLE_TWO_N_IN,
    input  wire logic                                   OUTPUT_ENABLE_N_IN,
    output logic      [fifo_flags_pkg::DATA_W-1:0]      READ_DATA_OUT,
    output logic                                        READ_DATA_OE_OUT,
    // flags
    output logic                                        FULL_FLAG_N_OUT,
    output logic                                        ALMOST_FULL_FLAG_N_OUT,
    output logic                                        EMPTY_FLAG_N_OUT,
    output logic                                        ALMOST_EMPTY_FLAG_N_OUT,
    // axi4-lite slave
    input  wire logic [fifo_flags_pkg::AXI_ADDR_W-1:0]  S_AXI_AWADDR,
    input  wire logic                                   S_AXI_AWVALID,
    output logic                                        S_AXI_AWREADY,
    input  wire logic [fifo_flags_pkg::AXI_DATA_W-1:0]  S_AXI_WDATA,
    input  wire logic [3:0]                             S_AXI_WSTRB,
    input  wire logic                                   S_AXI_WVALID,
    output logic                                        S_AXI_WREADY,
    output logic [1:0]                                  S_AXI_BRESP,
    output logic                                        S_AXI_BVALID,
    input  wire logic                                   S_AXI_BREADY,
    input  wire logic [fifo_flags_pkg::AXI_ADDR_W-1:0]  S_AXI_ARADDR,
    input  wire logic                                   S_AXI_ARVALID,
    output logic                                        S_AXI_ARREADY,
    output logic [fifo_flags_pkg::AXI_DATA_W-1:0]       S_AXI_RDATA,
    output logic [1:0]                                  S_AXI_RRESP,
    output logic                                        S_AXI_RVALID,
    input  wire logic                                   S_AXI_RREADY
);

    localparam int               PW    = ADDR_W + 1;
    localparam logic [ADDR_W:0]  DEPTH = PW'(1) << ADDR_W;
    localparam logic [ADDR_W-1:0] OFF_RST = ADDR_W'(fifo_flags_pkg::OFFSET_DEFAULT);

    function automatic logic [ADDR_W:0] gray_to_bin(input logic [ADDR_W:0] g);
        logic [ADDR_W:0] b;
        b = '0;
        b[ADDR_W] = g[ADDR_W];
        for (int i = ADDR_W - 1; i >= 0; i--)
        begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction : gray_to_bin

    // storage and state
    logic [fifo_flags_pkg::DATA_W-1:0] mem [2**ADDR_W];
    logic                   wclk_q, rclk_q, wr_edge, rd_edge;
    logic                   cfg_pending_q, dual_q;
    logic [ADDR_W:0]        wptr_q, rptr_q, wgray_q, rgray_q;
    logic [ADDR_W:0]        wgray_s1_q, wgray_s2_q, rgray_s1_q, rgray_s2_q;
    logic [ADDR_W:0]        wptr_d, rptr_d, wcnt_d, rcnt_d, af_level;
    logic [ADDR_W-1:0]      empty_off_q, full_off_q;
    logic [fifo_flags_pkg::DATA_W-1:0] q_q;
    logic                   full_n_q, af_n_q, empty_n_q, ae_n_q;
    logic                   do_write, do_read, ld_write, ld_read, load_mode;
    fifo_flags_pkg::offset_sel_t wsel_q, rsel_q;
    logic [fifo_flags_pkg::OFF_EXT_W-1:0] e_ext, f_ext;

    // pin edge detect: fifo clocks are sampled as ordinary inputs
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            wclk_q <= 1'b0;
            rclk_q <= 1'b0;
        end
        else
        begin
            wclk_q <= WRITE_CLOCK_IN;
            rclk_q <= READ_CLOCK_IN;
        end
    end
    assign wr_edge = WRITE_CLOCK_IN & ~wclk_q;
    assign rd_edge = READ_CLOCK_IN & ~rclk_q;

    // (R11) strap caught at reset release
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            cfg_pending_q <= 1'b1;
            dual_q        <= 1'b0;
        end
        else if (cfg_pending_q)
        begin
            cfg_pending_q <= 1'b0;
            dual_q        <= WRITE_ENABLE_TWO_OR_LOAD_IN;
        end
    end

    assign load_mode = ~dual_q & ~WRITE_ENABLE_TWO_OR_LOAD_IN & ~cfg_pending_q;
    // (R17) dual mode needs both enables; (R1) full refuses writes
    assign do_write  = wr_edge & ~cfg_pending_q & ~WRITE_ENABLE_ONE_N_IN
                     & WRITE_ENABLE_TWO_OR_LOAD_IN & full_n_q;
    // (R21) both read enables low; (R3) empty refuses reads
    assign do_read   = rd_edge & ~cfg_pending_q & ~READ_ENABLE_ONE_N_IN
                     & ~READ_ENABLE_TWO_N_IN & ~load_mode & empty_n_q;
    assign ld_write  = wr_edge & load_mode & ~WRITE_ENABLE_ONE_N_IN;
    assign ld_read   = rd_edge & load_mode & ~READ_ENABLE_ONE_N_IN & ~READ_ENABLE_TWO_N_IN;

    assign wptr_d = wptr_q + PW'(do_write);
    assign rptr_d = rptr_q + PW'(do_read);

    // write pointer and array, (R10) nine bits stored
    always_ff @(posedge CLK_IN)
    begin
        if (do_write)
        begin
            mem[wptr_q[ADDR_W-1:0]] <= WRITE_DATA_IN;
        end
    end

    // (R20) pointers to first location; (R24) gray copies for crossing
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            wptr_q  <= '0;
            rptr_q  <= '0;
            wgray_q <= '0;
            rgray_q <= '0;
        end
        else
        begin
            wptr_q  <= wptr_d;
            rptr_q  <= rptr_d;
            wgray_q <= wptr_d ^ (wptr_d >> 1);
            rgray_q <= rptr_d ^ (rptr_d >> 1);
        end
    end

    // (R24) two-flop synchronisers, first stage read only by second
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            wgray_s1_q <= '0;
            wgray_s2_q <= '0;
            rgray_s1_q <= '0;
            rgray_s2_q <= '0;
        end
        else
        begin
            wgray_s1_q <= wgray_q;
            wgray_s2_q <= wgray_s1_q;
            rgray_s1_q <= rgray_q;
            rgray_s2_q <= rgray_s1_q;
        end
    end

    assign wcnt_d   = wptr_d - gray_to_bin(rgray_s2_q);
    assign rcnt_d   = gray_to_bin(wgray_s2_q) - rptr_d;
    // (R5) threshold is depth minus m
    assign af_level = DEPTH - {1'b0, full_off_q};

    // (R2) write-side flags move only on write edges; (R14) lag from sync
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            full_n_q <= 1'b1;
            af_n_q   <= 1'b1;
        end
        else if (wr_edge)
        begin
            // (R1) full at depth; (R18) flag taken from post-write count
            full_n_q <= (wcnt_d != DEPTH);
            af_n_q   <= (wcnt_d < af_level);
        end
    end

    // (R4) read-side flags move only on read edges; (R15) (R16) sync lag
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            empty_n_q <= 1'b0;
            ae_n_q    <= 1'b0;
        end
        else if (rd_edge)
        begin
            // (R3) equal pointers; (R7) (R19) n or fewer holds almost-empty
            empty_n_q <= (rcnt_d != '0);
            ae_n_q    <= (rcnt_d > {1'b0, empty_off_q});
        end
    end

    assign e_ext = fifo_flags_pkg::OFF_EXT_W'(empty_off_q);
    assign f_ext = fifo_flags_pkg::OFF_EXT_W'(full_off_q);

    // (R12) output register zero after reset; load reads show offsets
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            q_q    <= '0;
            rsel_q <= fifo_flags_pkg::SEL_EMPTY_LO;
        end
        else if (do_read)
        begin
            q_q <= mem[rptr_q[ADDR_W-1:0]];
        end
        else if (ld_read)
        begin
            case (rsel_q)
                fifo_flags_pkg::SEL_EMPTY_LO:
                begin
                    q_q    <= {1'b0, e_ext[fifo_flags_pkg::OFF_LO_W-1:0]};
                    rsel_q <= fifo_flags_pkg::SEL_EMPTY_HI;
                end
                fifo_flags_pkg::SEL_EMPTY_HI:
                begin
                    q_q    <= e_ext[fifo_flags_pkg::OFF_EXT_W-1:fifo_flags_pkg::OFF_LO_W];
                    rsel_q <= fifo_flags_pkg::SEL_FULL_LO;
                end
                fifo_flags_pkg::SEL_FULL_LO:
                begin
                    q_q    <= {1'b0, f_ext[fifo_flags_pkg::OFF_LO_W-1:0]};
                    rsel_q <= fifo_flags_pkg::SEL_FULL_HI;
                end
                default:
                begin
                    q_q    <= f_ext[fifo_flags_pkg::OFF_EXT_W-1:fifo_flags_pkg::OFF_LO_W];
                    rsel_q <= fifo_flags_pkg::SEL_EMPTY_LO;
                end
            endcase
        end
    end

    // axi4-lite slave state
    logic                  aw_have_q, w_have_q, bvalid_q, rvalid_q;
    logic [11:0]           aw_addr_q;
    logic [31:0]           w_data_q, rdata_q, status_word, offset_word, merged;
    logic [3:0]            w_strb_q;
    logic [1:0]            bresp_q, rresp_q;
    logic                  axi_wr, off_hit;

    assign S_AXI_AWREADY = ~aw_have_q & ~bvalid_q;
    assign S_AXI_WREADY  = ~w_have_q & ~bvalid_q;
    assign S_AXI_ARREADY = ~rvalid_q;
    assign axi_wr        = aw_have_q & w_have_q & ~bvalid_q;
    assign off_hit       = (aw_addr_q == fifo_flags_pkg::REG_OFFSET);

    always_comb
    begin
        status_word = '0;
        status_word[fifo_flags_pkg::ST_FULL_N]      = full_n_q;
        status_word[fifo_flags_pkg::ST_ALMOST_FULL] = af_n_q;
        status_word[fifo_flags_pkg::ST_ALMOST_EMPT] = ae_n_q;
        status_word[fifo_flags_pkg::ST_EMPTY_N]     = empty_n_q;
        status_word[fifo_flags_pkg::ST_DUAL_MODE]   = dual_q;
        status_word[fifo_flags_pkg::ST_COUNT_LSB +: PW] = wptr_q - rptr_q;
        offset_word = '0;
        offset_word[fifo_flags_pkg::OF_EMPTY_LSB +: ADDR_W] = empty_off_q;
        offset_word[fifo_flags_pkg::OF_FULL_LSB +: ADDR_W]  = full_off_q;
        merged = offset_word;
        for (int b = 0; b < 4; b++)
        begin
            if (w_strb_q[b])
            begin
                merged[b*8 +: 8] = w_data_q[b*8 +: 8];
            end
        end
    end

    // write channel: address and data taken in either order
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= fifo_flags_pkg::RESP_OKAY;
        end
        else
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_have_q <= 1'b1;
                w_data_q <= S_AXI_WDATA;
                w_strb_q <= S_AXI_WSTRB;
            end
            if (axi_wr)
            begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= (off_hit || aw_addr_q == fifo_flags_pkg::REG_STATUS)
                           ? fifo_flags_pkg::RESP_OKAY : fifo_flags_pkg::RESP_SLVERR;
            end
            else if (bvalid_q && S_AXI_BREADY)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // read channel: one-cycle registered answer
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= fifo_flags_pkg::RESP_OKAY;
        end
        else if (S_AXI_ARVALID && S_AXI_ARREADY)
        begin
            rvalid_q <= 1'b1;
            case (S_AXI_ARADDR)
                fifo_flags_pkg::REG_STATUS:
                begin
                    rdata_q <= status_word;
                    rresp_q <= fifo_flags_pkg::RESP_OKAY;
                end
                fifo_flags_pkg::REG_OFFSET:
                begin
                    rdata_q <= offset_word;
                    rresp_q <= fifo_flags_pkg::RESP_OKAY;
                end
                default:
                begin
                    rdata_q <= '0;
                    rresp_q <= fifo_flags_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_q && S_AXI_RREADY)
        begin
            rvalid_q <= 1'b0;
        end
    end

    // (R20) (R6) (R8) offsets default to seven at reset
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            empty_off_q <= OFF_RST;
            full_off_q  <= OFF_RST;
            wsel_q      <= fifo_flags_pkg::SEL_EMPTY_LO;
        end
        else if (ld_write)
        begin
            // (R22) load walk with wrap after the fourth register
            case (wsel_q)
                fifo_flags_pkg::SEL_EMPTY_LO:
                begin
                    empty_off_q[fifo_flags_pkg::OFF_LO_W-1:0] <=
                        WRITE_DATA_IN[fifo_flags_pkg::OFF_LO_W-1:0];
                    wsel_q <= fifo_flags_pkg::SEL_EMPTY_HI;
                end
                fifo_flags_pkg::SEL_EMPTY_HI:
                begin
                    empty_off_q <= ADDR_W'({WRITE_DATA_IN,
                                   empty_off_q[fifo_flags_pkg::OFF_LO_W-1:0]});
                    wsel_q <= fifo_flags_pkg::SEL_FULL_LO;
                end
                fifo_flags_pkg::SEL_FULL_LO:
                begin
                    full_off_q[fifo_flags_pkg::OFF_LO_W-1:0] <=
                        WRITE_DATA_IN[fifo_flags_pkg::OFF_LO_W-1:0];
                    wsel_q <= fifo_flags_pkg::SEL_FULL_HI;
                end
                default:
                begin
                    full_off_q <= ADDR_W'({WRITE_DATA_IN,
                                  full_off_q[fifo_flags_pkg::OFF_LO_W-1:0]});
                    wsel_q <= fifo_flags_pkg::SEL_EMPTY_LO;
                end
            endcase
        end
        else if (axi_wr && off_hit)
        begin
            empty_off_q <= merged[fifo_flags_pkg::OF_EMPTY_LSB +: ADDR_W];
            full_off_q  <= merged[fifo_flags_pkg::OF_FULL_LSB +: ADDR_W];
        end
    end

    // outputs; (R23) enable follows the active-low output enable
    assign READ_DATA_OUT           = q_q;
    assign READ_DATA_OE_OUT        = ~OUTPUT_ENABLE_N_IN;
    assign FULL_FLAG_N_OUT         = full_n_q;
    assign ALMOST_FULL_FLAG_N_OUT  = af_n_q;
    assign EMPTY_FLAG_N_OUT        = empty_n_q;
    assign ALMOST_EMPTY_FLAG_N_OUT = ae_n_q;
    assign S_AXI_BVALID            = bvalid_q;
    assign S_AXI_BRESP             = bresp_q;
    assign S_AXI_RVALID            = rvalid_q;
    assign S_AXI_RDATA             = rdata_q;
    assign S_AXI_RRESP             = rresp_q;

    // checks
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);

    sequence s_full_held;
        !full_n_q;
    endsequence
    sequence s_wptr_kept;
        wptr_q == $past(wptr_q);
    endsequence

    property p_full_blocks;
        s_full_held |=> s_wptr_kept;
    endproperty
    a_full_blocks: assert property (p_full_blocks) else $error("write taken while full"); // R1

    property p_wflags_on_edge;
        !wr_edge |=> $stable(full_n_q) && $stable(af_n_q);
    endproperty
    a_wflags_on_edge: assert property (p_wflags_on_edge) else $error("write flag off edge"); // R2

    property p_empty_blocks;
        !empty_n_q |=> rptr_q == $past(rptr_q);
    endproperty
    a_empty_blocks: assert property (p_empty_blocks) else $error("read taken while empty"); // R3

    property p_rflags_on_edge;
        !rd_edge |=> $stable(empty_n_q) && $stable(ae_n_q);
    endproperty
    a_rflags_on_edge: assert property (p_rflags_on_edge) else $error("read flag off edge"); // R4

    property p_af_level;
        wr_edge && (wcnt_d >= af_level) |=> !af_n_q;
    endproperty
    a_af_level: assert property (p_af_level) else $error("almost-full missed"); // R5

    property p_band_order;
        (!full_n_q |-> !af_n_q) and (!empty_n_q |-> !ae_n_q);
    endproperty
    a_band_order: assert property (p_band_order) else $error("flag bands out of order"); // R9

    property p_dual_gate;
        dual_q && !WRITE_ENABLE_TWO_OR_LOAD_IN |=> s_wptr_kept;
    endproperty
    a_dual_gate: assert property (p_dual_gate) else $error("write with enable two low"); // R17

    property p_load_walk;
        ld_write && wsel_q == fifo_flags_pkg::SEL_FULL_HI
            |=> wsel_q == fifo_flags_pkg::SEL_EMPTY_LO;
    endproperty
    a_load_walk: assert property (p_load_walk) else $error("load walk did not wrap"); // R22

    property p_gray_step;
        $countones(wgray_q ^ $past(wgray_q)) <= 1;
    endproperty
    a_gray_step: assert property (p_gray_step) else $error("gray pointer jumped"); // R24

endmodule : fifo_flags

/* File: test/fifo_far_side.sv */
// Purpose: writer and reader logic facing the fifo
// Assumes: fifo clocks are levels paced by the system clock
// Notes:   idle write data shows the inverse of the last word
`timescale 1ns/1ps
module fifo_far_side (
    // system
    input  wire logic       clk_in,
    // writer
    output logic            wclk_out,
    output logic [8:0]      wdata_out,
    output logic            we1_n_out,
    output logic            we2_out,
    // reader
    output logic            rclk_out,
    output logic            re1_n_out,
    output logic            re2_n_out
);
    initial
    begin
        {wclk_out, wdata_out, we1_n_out, we2_out} = 12'h003;
        {rclk_out, re1_n_out, re2_n_out} = 3'h3;
    end
    task automatic push(input logic [8:0] d, input logic e2);
        @(posedge clk_in);
        {wclk_out, wdata_out, we1_n_out, we2_out} <= {1'b1, d, 1'b0, e2};
        repeat (2) @(posedge clk_in);
        {wclk_out, wdata_out, we1_n_out, we2_out} <= {1'b0, ~d, 2'h3};
        repeat (2) @(posedge clk_in);
    endtask : push
    task automatic pull(input logic hold);
        @(posedge clk_in);
        {rclk_out, re1_n_out, re2_n_out} <= {2'h2, hold};
        repeat (2) @(posedge clk_in);
        {rclk_out, re1_n_out, re2_n_out} <= 3'h3;
        repeat (2) @(posedge clk_in);
    endtask : pull
endmodule : fifo_far_side

/* File: test/tb.sv */
// Purpose: self-checking bench for the flagged fifo
// Assumes: depth 256, dual write enable mode
// Notes:   expected flags come from the word count
`timescale 1ns/1ps
module tb;
    logic        CLK_IN, RESETN_IN, OUTPUT_ENABLE_N_IN, WRITE_CLOCK_IN, READ_CLOCK_IN;
    logic        WRITE_ENABLE_ONE_N_IN, WRITE_ENABLE_TWO_OR_LOAD_IN, READ_DATA_OE_OUT;
    logic        READ_ENABLE_ONE_N_IN, READ_ENABLE_TWO_N_IN, FULL_FLAG_N_OUT;
    logic        ALMOST_FULL_FLAG_N_OUT, EMPTY_FLAG_N_OUT, ALMOST_EMPTY_FLAG_N_OUT;
    logic [8:0]  WRITE_DATA_IN, READ_DATA_OUT, q[$];
    logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA, seed, v;
    logic [3:0]  S_AXI_WSTRB;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
    logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
    logic        S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
    int          n_errors = 0, n_checks = 0;
    fifo_flags #(.ADDR_W(8)) i_fifo_flags (.CLK_IN, .RESETN_IN, .WRITE_CLOCK_IN,
        .WRITE_DATA_IN, .WRITE_ENABLE_ONE_N_IN, .WRITE_ENABLE_TWO_OR_LOAD_IN, .READ_CLOCK_IN,
        .READ_ENABLE_ONE_N_IN, .READ_ENABLE_TWO_N_IN, .OUTPUT_ENABLE_N_IN, .READ_DATA_OUT,
        .READ_DATA_OE_OUT, .FULL_FLAG_N_OUT, .ALMOST_FULL_FLAG_N_OUT, .EMPTY_FLAG_N_OUT,
        .ALMOST_EMPTY_FLAG_N_OUT, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
        .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
        .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
        .S_AXI_RVALID, .S_AXI_RREADY);
    fifo_far_side i_fifo_far_side (.clk_in(CLK_IN), .wclk_out(WRITE_CLOCK_IN),
        .wdata_out(WRITE_DATA_IN), .we1_n_out(WRITE_ENABLE_ONE_N_IN),
        .we2_out(WRITE_ENABLE_TWO_OR_LOAD_IN), .rclk_out(READ_CLOCK_IN),
        .re1_n_out(READ_ENABLE_ONE_N_IN), .re2_n_out(READ_ENABLE_TWO_N_IN));
    initial
    begin
        CLK_IN = 1'b0;
        forever #2.5 CLK_IN = ~CLK_IN;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // flags {full, almost full, almost empty, empty} for a word count
    function automatic logic [3:0] want(input int c);
        return {c != 256, c < 256 - fifo_flags_pkg::OFFSET_DEFAULT,
                c > fifo_flags_pkg::OFFSET_DEFAULT, c != 0};
    endfunction : want
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge CLK_IN);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA  <= d;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
        do
        begin
            @(posedge CLK_IN);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end while (!S_AXI_BVALID);
        S_AXI_BREADY <= 1'b0;
        chk(S_AXI_BRESP, er);
    endtask : axw
    task automatic axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge CLK_IN);
        S_AXI_ARADDR <= a;
        {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
        do
        begin
            @(posedge CLK_IN);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (!S_AXI_RVALID);
        S_AXI_RREADY <= 1'b0;
        chk({S_AXI_RRESP, S_AXI_RDATA}, {er, ed});
    endtask : axr
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    initial
    begin
        #100000;
        n_errors++;
        wrap_up();
    end
    initial
    begin
        seed = 32'h0001_5F9B;
        {RESETN_IN, OUTPUT_ENABLE_N_IN, S_AXI_WSTRB} = 6'h0F;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
        repeat (6) @(posedge CLK_IN);
        chk({FULL_FLAG_N_OUT, ALMOST_FULL_FLAG_N_OUT, ALMOST_EMPTY_FLAG_N_OUT,
             EMPTY_FLAG_N_OUT, READ_DATA_OUT}, {4'hC, 9'h000});
        RESETN_IN <= 1'b1;
        axr(fifo_flags_pkg::REG_OFFSET, 32'h0007_0007, fifo_flags_pkg::RESP_OKAY);
        axr(fifo_flags_pkg::REG_STATUS, 32'h0000_0013, fifo_flags_pkg::RESP_OKAY);
        axr(12'h010, 32'h0000_0000, fifo_flags_pkg::RESP_SLVERR);
        i_fifo_far_side.push(9'h1FF, 1'b0);
        axr(fifo_flags_pkg::REG_STATUS, 32'h0000_0013, fifo_flags_pkg::RESP_OKAY);
        $display("test setup done");
        for (int i = 0; i < 256; i++)
        begin
            v = xs();
            q.push_back(v[8:0]);
            OUTPUT_ENABLE_N_IN <= v[9];
            i_fifo_far_side.push(v[8:0], 1'b1);
            chk({FULL_FLAG_N_OUT, ALMOST_FULL_FLAG_N_OUT}, want(i + 1) >> 2);
            chk(READ_DATA_OE_OUT, !OUTPUT_ENABLE_N_IN);
        end
        i_fifo_far_side.push(9'h0AA, 1'b1);
        axr(fifo_flags_pkg::REG_STATUS, 32'h0100_0010, fifo_flags_pkg::RESP_OKAY);
        $display("test fill done");
        i_fifo_far_side.pull(1'b1);
        chk({ALMOST_EMPTY_FLAG_N_OUT, EMPTY_FLAG_N_OUT, READ_DATA_OUT}, {2'h3, 9'h000});
        for (int i = 0; i < 256; i++)
        begin
            i_fifo_far_side.pull(1'b0);
            chk(READ_DATA_OUT, q[i]);
            chk({ALMOST_EMPTY_FLAG_N_OUT, EMPTY_FLAG_N_OUT}, want(255 - i) & 4'h3);
        end
        i_fifo_far_side.pull(1'b0);
        chk(READ_DATA_OUT, q[255]);
        $display("test drain done");
        axw(fifo_flags_pkg::REG_OFFSET, 32'h0005_0003, fifo_flags_pkg::RESP_OKAY);
        axr(fifo_flags_pkg::REG_OFFSET, 32'h0005_0003, fifo_flags_pkg::RESP_OKAY);
        $display("test offsets done");
        wrap_up();
    end
endmodule : tb
